// file: logic/tpil_pkg.sv
// shared constants, types and state records of the trigger port block
package tpil_pkg;
    localparam int unsigned PORT_COUNT = 2;
    localparam int unsigned COUNT_WIDTH = 16;
    localparam int unsigned CFG_WIDTH = 4;
    localparam int unsigned CFG_BITS = PORT_COUNT * CFG_WIDTH;
    localparam logic [7:0] CTRL_OFFSET = 8'h00;
    localparam logic [7:0] DRIVE_OFFSET = 8'h04;
    localparam logic [7:0] STATUS_OFFSET = 8'h08;
    localparam logic [7:0] EDGE_OFFSET = 8'h0C;
    localparam logic [7:0] COUNT_OFFSET = 8'h10;
    localparam logic SYNC_IDLE = 1'h1;
    localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

    typedef enum logic [2:0] {
        MODE_DISABLED, MODE_GPI, MODE_REL, MODE_ABS, MODE_HOME, MODE_GPO
    } tpil_mode_type;

    typedef struct packed {logic pol; tpil_mode_type mode;} tpil_cfg_type;
    typedef struct packed {logic level; logic rel; logic abs; logic home;} tpil_evt_type;
    typedef struct packed {logic out; logic oe;} tpil_pin_type;

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic armed;
        tpil_evt_type evt;
        tpil_pin_type pin;
    } tpil_port_state_type;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        tpil_cfg_type [PORT_COUNT-1:0] cfg;
        logic [PORT_COUNT-1:0] drive;
        logic [PORT_COUNT-1:0] edge_seen;
        logic rel;
        logic abs;
        logic home;
        logic [PORT_COUNT-1:0] src;
        logic [COUNT_WIDTH-1:0] count;
    } tpil_top_state_type;

    localparam tpil_cfg_type CFG_RESET = '{pol: 1'h1, mode: MODE_DISABLED};
    localparam tpil_port_state_type PORT_STATE_RESET = '{
        sync1: SYNC_IDLE, sync2: SYNC_IDLE, armed: 1'h0, evt: '0, pin: '0};
    localparam tpil_top_state_type TOP_STATE_RESET = '{
        ack: 1'h0, rdata: '0, cfg: {PORT_COUNT{CFG_RESET}}, drive: '0,
        edge_seen: '0, rel: 1'h0, abs: 1'h0, home: 1'h0, src: '0, count: '0};
endpackage

// file: logic/tpil_port.sv
// one trigger port: pin synchroniser, edge qualifier and pin driver
`timescale 1ns/1ps
`default_nettype none
module tpil_port
    import tpil_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic pin_in,
    input var tpil_cfg_type cfg,
    input wire logic drive_level,
    output var tpil_evt_type evt,
    output var tpil_pin_type pin
);
    tpil_port_state_type state;
    tpil_port_state_type next_state;
    logic asserted;
    logic move_mode;
    logic gpi_mode;
    logic gpo_mode;
    logic fire_any;

    always_comb begin
        next_state = state;
        move_mode = 1'h0;
        gpi_mode = 1'h0;
        gpo_mode = 1'h0;
        unique case (cfg.mode)
            MODE_DISABLED: begin
                move_mode = 1'h0;
            end
            MODE_GPI: begin
                gpi_mode = 1'h1;
            end
            MODE_REL, MODE_ABS, MODE_HOME: begin
                move_mode = 1'h1;
            end
            MODE_GPO: begin
                gpo_mode = 1'h1;
            end
            // codes 6 and 7 behave as disabled
            default: begin
                move_mode = 1'h0;
            end
        endcase
        next_state.sync1 = pin_in;
        next_state.sync2 = state.sync1;
        asserted = (state.sync2 == cfg.pol);
        // armed only after an inactive sample, so a held level fires once
        next_state.armed = move_mode && !asserted;
        next_state.evt.rel = state.armed && asserted && cfg.mode == MODE_REL;
        next_state.evt.abs = state.armed && asserted && cfg.mode == MODE_ABS;
        next_state.evt.home = state.armed && asserted && cfg.mode == MODE_HOME;
        next_state.evt.level = gpi_mode && state.sync2;
        next_state.pin.oe = gpo_mode;
        next_state.pin.out = gpo_mode && (drive_level ~^ cfg.pol);
    end

    // idle value high matches the pull-up of an unconnected pin
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= PORT_STATE_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign evt = state.evt;
    assign pin = state.pin;
    assign fire_any = state.evt.rel || state.evt.abs || state.evt.home;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    static_level_a: assert property (asserted && $past(asserted) |=> !fire_any)
        else $error("move fired on a static level");
    active_edge_a: assert property (fire_any |-> $past(asserted) && !$past(asserted, 2))
        else $error("move fired without an inactive to active change");
    one_move_a: assert property (fire_any |=> !fire_any)
        else $error("held level fired twice");
    disabled_quiet_a: assert property (
        cfg.mode == MODE_DISABLED |=> !state.pin.oe && !fire_any && !state.evt.level)
        else $error("disabled port shows activity");
    polarity_edge_a: assert property (fire_any |-> $past(state.sync2) == $past(cfg.pol))
        else $error("edge direction does not match polarity");
    sync_delay_a: assert property (fire_any |->
        $past(pin_in, 3) == $past(cfg.pol) && $past(pin_in, 4) != $past(cfg.pol, 2))
        else $error("move request not three cycles after the pin edge");
endmodule
`default_nettype wire

// file: logic/tpil_top.sv
// trigger port block: two ports, move requests and a wishbone register slave
// Operation
// - There are two trigger ports, each able to read a level in or drive a level out.
// - Each port is set to input or output independently of the other.
// - Each port holds its own active level, high or low.
// - A move-launching input reacts to a change of level, never to a static level.
// - A move trigger is only a change from the inactive to the active level.
// - A held active level launches one move; the line must go inactive before the next.
// - A disabled port drives nothing and gives no trigger or status effect.
// - In general-purpose input mode the sampled pin level is readable as a status bit.
// - In relative mode a trigger edge requests a relative move.
// - In absolute mode a trigger edge requests an absolute move.
// - In home mode a trigger edge requests a homing move.
// - An unconnected input reads high, so a switch to ground can trigger.
// - Active-high triggers on a rising edge, active-low on a falling edge.
`timescale 1ns/1ps
`default_nettype none
module tpil_top
    import tpil_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic trigger_port_one_in,
    output logic trigger_port_one_out,
    output logic trigger_port_one_oe,
    input wire logic trigger_port_two_in,
    output logic trigger_port_two_out,
    output logic trigger_port_two_oe,
    output logic move_rel_req,
    output logic move_abs_req,
    output logic move_home_req,
    output logic [1:0] move_src
);
    logic [1:0] rst_pipe;
    logic rst_n;
    tpil_top_state_type state;
    tpil_top_state_type next_state;
    logic [PORT_COUNT-1:0] pin_in_vec;
    tpil_evt_type [PORT_COUNT-1:0] evt_vec;
    tpil_pin_type [PORT_COUNT-1:0] pin_vec;
    logic [PORT_COUNT-1:0] level_vec;
    logic [PORT_COUNT-1:0] fired;
    logic [PORT_COUNT-1:0] edge_clear;
    logic req;
    logic wr;
    logic any_rel;
    logic any_abs;
    logic any_home;
    logic [31:0] rd;

    // reset is asserted at once but released only after two clean edges
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'h1};
        end
    end

    assign rst_n = rst_pipe[1];
    assign pin_in_vec = {trigger_port_two_in, trigger_port_one_in};

    for (genvar i = 0; i < PORT_COUNT; i++) begin : gen_port
        tpil_port u_port (
            .core_clk(core_clk),
            .rst_n(rst_n),
            .pin_in(pin_in_vec[i]),
            .cfg(state.cfg[i]),
            .drive_level(state.drive[i]),
            .evt(evt_vec[i]),
            .pin(pin_vec[i])
        );
    end

    always_comb begin
        level_vec = '0;
        fired = '0;
        any_rel = 1'h0;
        any_abs = 1'h0;
        any_home = 1'h0;
        for (int i = 0; i < PORT_COUNT; i++) begin
            level_vec[i] = evt_vec[i].level;
            fired[i] = evt_vec[i].rel || evt_vec[i].abs || evt_vec[i].home;
            any_rel = any_rel || evt_vec[i].rel;
            any_abs = any_abs || evt_vec[i].abs;
            any_home = any_home || evt_vec[i].home;
        end
    end

    always_comb begin
        next_state = state;
        req = wb_cyc_i && wb_stb_i;
        // one wait state: data is prepared while ack is still low
        next_state.ack = req && !state.ack;
        case (wb_adr_i)
            CTRL_OFFSET: begin
                rd = 32'(state.cfg);
            end
            DRIVE_OFFSET: begin
                rd = 32'(state.drive);
            end
            STATUS_OFFSET: begin
                rd = 32'(level_vec);
            end
            EDGE_OFFSET: begin
                rd = 32'(state.edge_seen);
            end
            COUNT_OFFSET: begin
                rd = 32'(state.count);
            end
            default: begin
                rd = UNMAPPED_DATA;
            end
        endcase
        if (req && !state.ack) begin
            next_state.rdata = rd;
        end
        // writes land on the edge where the master samples ack
        wr = req && state.ack && wb_we_i && wb_sel_i[0];
        edge_clear = '0;
        if (wr) begin
            case (wb_adr_i)
                CTRL_OFFSET: begin
                    next_state.cfg = wb_dat_i[CFG_BITS-1:0];
                end
                DRIVE_OFFSET: begin
                    next_state.drive = wb_dat_i[PORT_COUNT-1:0];
                end
                EDGE_OFFSET: begin
                    edge_clear = wb_dat_i[PORT_COUNT-1:0];
                end
                default: begin
                    edge_clear = '0;
                end
            endcase
        end
        // a new edge in the clearing cycle survives the clear
        next_state.edge_seen = (state.edge_seen & ~edge_clear) | fired;
        next_state.rel = any_rel;
        next_state.abs = any_abs;
        next_state.home = any_home;
        next_state.src = fired;
        // counts cycles with a request; two ports in one cycle count once
        next_state.count = state.count + COUNT_WIDTH'(|fired);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= TOP_STATE_RESET;
        end else begin
            state <= next_state;
        end
    end

    assign wb_ack_o = state.ack;
    assign wb_dat_o = state.rdata;
    assign move_rel_req = state.rel;
    assign move_abs_req = state.abs;
    assign move_home_req = state.home;
    assign move_src = state.src;
    assign trigger_port_one_out = pin_vec[0].out;
    assign trigger_port_one_oe = pin_vec[0].oe;
    assign trigger_port_two_out = pin_vec[1].out;
    assign trigger_port_two_oe = pin_vec[1].oe;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    for (genvar i = 0; i < PORT_COUNT; i++) begin : gen_check
        drive_mode_a: assert property (
            pin_vec[i].oe == ($past(state.cfg[i].mode) == MODE_GPO))
            else $error("output enable does not follow output mode");
        drive_level_a: assert property (pin_vec[i].oe |->
            pin_vec[i].out == ($past(state.drive[i]) ~^ $past(state.cfg[i].pol)))
            else $error("driven level ignores polarity");
    end

    cfg_write_a: assert property (
        wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0]
        && wb_adr_i == CTRL_OFFSET |=> state.cfg == $past(wb_dat_i[CFG_BITS-1:0]))
        else $error("configuration write not stored");
    status_read_a: assert property (
        wb_ack_o && !wb_we_i && wb_adr_i == STATUS_OFFSET
        |-> wb_dat_o == 32'($past(level_vec)))
        else $error("status read does not show port levels");
    rel_route_a: assert property (move_rel_req |->
        $past(state.cfg[0].mode == MODE_REL, 2) || $past(state.cfg[1].mode == MODE_REL, 2))
        else $error("relative request without relative mode");
    abs_route_a: assert property (move_abs_req |->
        $past(state.cfg[0].mode == MODE_ABS, 2) || $past(state.cfg[1].mode == MODE_ABS, 2))
        else $error("absolute request without absolute mode");
    home_route_a: assert property (move_home_req |->
        $past(state.cfg[0].mode == MODE_HOME, 2) || $past(state.cfg[1].mode == MODE_HOME, 2))
        else $error("home request without home mode");
    ack_single_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    rel_seen_c: cover property (move_rel_req);
    abs_seen_c: cover property (move_abs_req);
    home_seen_c: cover property (move_home_req);
    gpi_read_c: cover property (wb_ack_o && wb_adr_i == STATUS_OFFSET && wb_dat_o[0]);
endmodule
`default_nettype wire

// file: verif/tpil_ext_drv.sv
// model of the outside equipment on one trigger line, with the pin's weak pull-up
`timescale 1ns/1ps
`default_nettype none
module tpil_ext_drv (
    input wire logic dut_oe,
    input wire logic dut_out,
    input wire logic ext_en,
    input wire logic ext_val,
    output logic pin
);
    // a released line floats up to 1, so a contact to ground is a valid source
    assign pin = dut_oe ? dut_out : (ext_en ? ext_val : 1'h1);
endmodule
`default_nettype wire

// file: verif/testbench.sv
// self-checking bench of the trigger port block with two line drivers
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((e) !== (g)) begin n_fail++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module testbench;
    import tpil_pkg::*;
    logic core_clk = 1'h0;
    logic rstn = 1'h0;
    logic cyc = 1'h0, stb = 1'h0, we = 1'h0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'hF;
    logic [31:0] wdat = 32'h0, rdat;
    logic ack, rel, abs_r, home, o1, oe1, o2, oe2, pin1, pin2;
    logic [1:0] src, ext_en = 2'h3, ext_val = 2'h3, src_acc = 2'h0;
    logic [15:0] exp_count = 16'h0;
    int n_fail = 0, samples_checked = 0, n_rel = 0, n_abs = 0, n_home = 0;
    always #10 core_clk = ~core_clk;
    tpil_top dut (.core_clk(core_clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .trigger_port_one_in(pin1), .trigger_port_one_out(o1),
        .trigger_port_one_oe(oe1), .trigger_port_two_in(pin2), .trigger_port_two_out(o2),
        .trigger_port_two_oe(oe2), .move_rel_req(rel), .move_abs_req(abs_r),
        .move_home_req(home), .move_src(src));
    tpil_ext_drv drv_one (.dut_oe(oe1), .dut_out(o1), .ext_en(ext_en[0]),
        .ext_val(ext_val[0]), .pin(pin1));
    tpil_ext_drv drv_two (.dut_oe(oe2), .dut_out(o2), .ext_en(ext_en[1]),
        .ext_val(ext_val[1]), .pin(pin2));
    always @(posedge core_clk) begin
        if (rel === 1'h1) n_rel <= n_rel + 1;
        if (abs_r === 1'h1) n_abs <= n_abs + 1;
        if (home === 1'h1) n_home <= n_home + 1;
        if ((rel | abs_r | home) === 1'h1) src_acc <= src_acc | src;
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int t;
        t = 0;
        @(posedge core_clk);
        cyc <= 1'h1; stb <= 1'h1; we <= w; adr <= a; wdat <= d;
        do begin
            @(posedge core_clk);
            t++;
        end while (ack !== 1'h1 && t < 50);
        if (t >= 50) n_fail++;
        q = rdat;
        cyc <= 1'h0; stb <= 1'h0; we <= 1'h0;
        @(posedge core_clk);
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'h0, a, 32'h0, q);
        `CHK(nm, e, q)
    endtask
    // one port in one mode: arm at inactive, then hold active for many cycles
    task automatic fire(input int p, input tpil_mode_type m, input logic pol);
        logic [31:0] q;
        logic [7:0] ctrl;
        int r0, a0, h0;
        bit mv;
        ctrl = (p == 0) ? {4'h8, pol, m} : {pol, m, 4'h8};
        mv = (m == MODE_REL) || (m == MODE_ABS) || (m == MODE_HOME);
        // park both ports first: a polarity flip on an armed port would fire a stray move
        bus(1'h1, CTRL_OFFSET, 32'h88, q);
        ext_en[p] <= 1'h1; ext_val[p] <= ~pol;
        repeat (3) @(posedge core_clk);
        bus(1'h1, CTRL_OFFSET, {24'h0, ctrl}, q);
        repeat (4 + $urandom_range(3)) @(posedge core_clk);
        r0 = n_rel; a0 = n_abs; h0 = n_home; src_acc <= 2'h0;
        ext_val[p] <= pol;
        repeat (14) @(posedge core_clk);
        `CHK("rel", r0 + int'(m == MODE_REL), n_rel)
        `CHK("abs", a0 + int'(m == MODE_ABS), n_abs)
        `CHK("home", h0 + int'(m == MODE_HOME), n_home)
        `CHK("src", mv ? 2'(1 << p) : 2'h0, src_acc)
        rd_chk("edge", EDGE_OFFSET, mv ? 32'(1 << p) : 32'h0);
        bus(1'h1, EDGE_OFFSET, 32'h3, q);
        rd_chk("edge clr", EDGE_OFFSET, 32'h0);
        if (mv) exp_count++;
        rd_chk("count", COUNT_OFFSET, {16'h0, exp_count});
        ext_val[p] <= ~pol;
        repeat (3) @(posedge core_clk);
    endtask
    initial begin
        logic [31:0] q;
        logic pol;
        int p;
        void'($urandom(32'h352b));
        repeat (6) @(posedge core_clk);
        rstn <= 1'h1;
        repeat (3) @(posedge core_clk);
        `CHK("oe", 2'h0, {oe2, oe1})
        rd_chk("ctrl rst", CTRL_OFFSET, 32'h88);
        rd_chk("status rst", STATUS_OFFSET, 32'h0);
        rd_chk("unmapped", 8'h40, UNMAPPED_DATA);
        sel <= 4'hE;
        bus(1'h1, CTRL_OFFSET, 32'h11, q);
        sel <= 4'hF;
        rd_chk("ctrl sel", CTRL_OFFSET, 32'h88);
        for (int m = 0; m < 5; m++)
            for (int k = 0; k < 2; k++)
                fire($urandom_range(1), tpil_mode_type'(m), k[0]);
        fire(0, MODE_REL, 1'h1);
        fire(0, MODE_REL, 1'h1);
        // general input on one port, released lines must read high
        ext_en <= 2'h0;
        p = $urandom_range(1);
        bus(1'h1, CTRL_OFFSET, (p == 0) ? 32'h89 : 32'h98, q);
        repeat (4) @(posedge core_clk);
        rd_chk("gpi float", STATUS_OFFSET, 32'(1 << p));
        ext_en[p] <= 1'h1; ext_val[p] <= 1'h0;
        repeat (4) @(posedge core_clk);
        rd_chk("gpi low", STATUS_OFFSET, 32'h0);
        // port one drives out while port two stays an input
        pol = 1'($urandom_range(1));
        ext_en <= 2'h0;
        q = $urandom_range(3);
        bus(1'h1, CTRL_OFFSET, {24'h0, 4'h9, pol, 3'h5}, q);
        bus(1'h1, DRIVE_OFFSET, 32'h1, q);
        repeat (3) @(posedge core_clk);
        `CHK("oe pair", 2'h1, {oe2, oe1})
        `CHK("out one", ~(1'h1 ^ pol), o1)
        rd_chk("gpi two", STATUS_OFFSET, 32'h2);
        wrap_up();
    end
    initial begin
        #(20 * 20000);
        n_fail++;
        wrap_up();
    end
endmodule
`default_nettype wire
